/* ivc_indexed_cmd.sv */
// Purpose: Executes the indexed user variable and indexed axis parameter commands.
// Assumes: Accumulator and X register belong to this block; a loader may preset them.
// Notes:   Every checked frame gets one reply; unknown instructions answer with an error.
`timescale 1ns/1ps
module ivc_indexed_cmd
#(
   parameter int NUM_VARS = 256
)
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              byte_valid,
   input  wire logic [7:0]        byte_data,
   input  wire logic              reg_load,
   input  wire logic [31:0]       accu_in,
   input  wire logic [31:0]       xreg_in,
   output logic [31:0]            accu,
   output logic [31:0]            xreg,
   output logic                   axis_wr_valid,
   output ivc_pkg::ivc_axis_wr_s  axis_wr,
   output logic                   reply_valid,
   output ivc_pkg::ivc_reply_s    reply
);
   import ivc_pkg::*;

   logic         frame_valid;
   ivc_frame_s   frame;
   logic         csum_ok;
   logic [31:0]  uvar [NUM_VARS];
   logic [31:0]  next_accu;
   logic [31:0]  next_xreg;
   logic         var_we;
   logic [7:0]   var_idx;
   logic [31:0]  var_wdata;
   logic         next_axis_wr_valid;
   ivc_axis_wr_s next_axis_wr;
   logic         next_reply_valid;
   ivc_reply_s   next_reply;
   logic         idx_ok;
   logic         exec;
   logic         do_axis_wr;
   logic         do_var_set;
   logic         do_var_get;
   logic         do_var_put;
   logic         op_known;

   // Index is taken as signed; negative values fall outside the array.
   function automatic logic index_in_range(input logic [31:0] x);
      index_in_range = !x[31] && (x <= IVC_IDX_MAX);
   endfunction : index_in_range

   ivc_frame_rx u_rx
   (
      .clk         (clk),
      .rst_n       (rst_n),
      .byte_valid  (byte_valid),
      .byte_data   (byte_data),
      .frame_valid (frame_valid),
      .frame       (frame),
      .csum_ok     (csum_ok)
   );

   // A frame acts only when its checksum holds; a bad frame still gets a reply.
   assign exec   = frame_valid && csum_ok;
   assign idx_ok = index_in_range(xreg);

   // Instruction decode; type and bank bytes play no part in selecting a command.
   always_comb
   begin
      do_axis_wr = 1'b0;
      do_var_set = 1'b0;
      do_var_get = 1'b0;
      do_var_put = 1'b0;
      op_known   = 1'b1;
      case (frame.instr)
         IVC_OP_ACCU_TO_AXIS_PARAM_BY_INDEX:
         begin
            do_axis_wr = exec;
         end
         IVC_OP_SET_INDEXED_USER_VAR:
         begin
            do_var_set = exec;
         end
         IVC_OP_GET_INDEXED_USER_VAR:
         begin
            do_var_get = exec;
         end
         IVC_OP_ACCU_TO_INDEXED_USER_VAR:
         begin
            do_var_put = exec;
         end
         default:
         begin
            op_known = 1'b0;
         end
      endcase
   end

   // Accumulator and X register; a read of a user variable wins over a preset.
   always_comb
   begin
      next_accu = accu;
      next_xreg = xreg;
      if (reg_load)
      begin
         next_accu = accu_in;
         next_xreg = xreg_in;
      end
      if (do_var_get && idx_ok)
      begin
         next_accu = uvar[var_idx];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         accu <= IVC_WORD_RST;
         xreg <= IVC_WORD_RST;
      end
      else
      begin
         accu <= next_accu;
         xreg <= next_xreg;
      end
   end

   // User variable write port; an index outside the array suppresses the write.
   always_comb
   begin
      var_we    = 1'b0;
      var_idx   = xreg[7:0];
      var_wdata = accu;
      if (do_var_set)
      begin
         var_we    = idx_ok;
         var_wdata = frame.value;
      end
      else if (do_var_put)
      begin
         var_we    = idx_ok;
         var_wdata = accu;
      end
   end

   // Axis parameter write request; the axis index is not range checked.
   always_comb
   begin
      next_axis_wr_valid = do_axis_wr;
      next_axis_wr       = axis_wr;
      if (do_axis_wr)
      begin
         next_axis_wr.axis  = xreg[7:0];
         next_axis_wr.param = frame.ptype;
         next_axis_wr.value = accu;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         axis_wr_valid <= 1'b0;
         axis_wr       <= '0;
      end
      else
      begin
         axis_wr_valid <= next_axis_wr_valid;
         axis_wr       <= next_axis_wr;
      end
   end

   // Reply to every received frame; the value field carries no data.
   always_comb
   begin
      next_reply_valid = frame_valid;
      next_reply       = reply;
      if (frame_valid)
      begin
         next_reply.addr  = frame.addr;
         next_reply.instr = frame.instr;
         next_reply.value = IVC_WORD_RST;
         if (!csum_ok)
         begin
            next_reply.status = IVC_ST_BAD_CSUM;
         end
         else if (op_known)
         begin
            next_reply.status = IVC_ST_OK;
         end
         else
         begin
            next_reply.status = IVC_ST_BAD_CMD;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reply_valid <= 1'b0;
         reply       <= '0;
      end
      else
      begin
         reply_valid <= next_reply_valid;
         reply       <= next_reply;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_VARS; i++)
         begin
            uvar[i] <= IVC_WORD_RST;
         end
      end
      else if (var_we)
      begin
         uvar[var_idx] <= var_wdata;
      end
   end

endmodule : ivc_indexed_cmd

/* ivc_pkg.sv */
// Purpose: Shared constants and carrier types for the indexed variable command block.
// Assumes: Frames arrive as a byte stream from a transport on the same clock.
// Notes:   Reply status values are the documented protocol codes.
package ivc_pkg;

   localparam int          IVC_FRAME_LEN   = 9;
   localparam logic [3:0]  IVC_POS_ADDR    = 4'h0;
   localparam logic [3:0]  IVC_POS_INSTR   = 4'h1;
   localparam logic [3:0]  IVC_POS_TYPE    = 4'h2;
   localparam logic [3:0]  IVC_POS_BANK    = 4'h3;
   localparam logic [3:0]  IVC_POS_VAL3    = 4'h4;
   localparam logic [3:0]  IVC_POS_CSUM    = 4'h8;
   localparam logic [3:0]  IVC_CNT_RST     = 4'h0;

   localparam logic [7:0]  IVC_OP_ACCU_TO_AXIS_PARAM_BY_INDEX = 8'h12;
   localparam logic [7:0]  IVC_OP_SET_INDEXED_USER_VAR        = 8'h37;
   localparam logic [7:0]  IVC_OP_GET_INDEXED_USER_VAR        = 8'h38;
   localparam logic [7:0]  IVC_OP_ACCU_TO_INDEXED_USER_VAR    = 8'h39;

   localparam logic [7:0]  IVC_ST_OK       = 8'h64;
   localparam logic [7:0]  IVC_ST_BAD_CSUM = 8'h01;
   localparam logic [7:0]  IVC_ST_BAD_CMD  = 8'h02;

   localparam logic [31:0] IVC_IDX_MAX     = 32'h0000_00FF;
   localparam logic [31:0] IVC_WORD_RST    = 32'h0000_0000;
   localparam logic [7:0]  IVC_BYTE_RST    = 8'h00;

   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  instr;
      logic [7:0]  ptype;
      logic [7:0]  bank;
      logic [31:0] value;
      logic [7:0]  csum;
   } ivc_frame_s;

   typedef struct packed {
      logic [7:0]  addr;
      logic [7:0]  status;
      logic [7:0]  instr;
      logic [31:0] value;
   } ivc_reply_s;

   typedef struct packed {
      logic [7:0]  axis;
      logic [7:0]  param;
      logic [31:0] value;
   } ivc_axis_wr_s;

endpackage : ivc_pkg

/* ivc_frame_rx.sv */
// Purpose: Collects nine bytes into one command frame and checks its checksum.
// Assumes: Bytes arrive on the same clock with a valid strobe.
// Notes:   A frame is presented for one cycle once the ninth byte is in.
`timescale 1ns/1ps
module ivc_frame_rx
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              byte_valid,
   input  wire logic [7:0]        byte_data,
   output logic                   frame_valid,
   output ivc_pkg::ivc_frame_s    frame,
   output logic                   csum_ok
);
   import ivc_pkg::*;

   logic [3:0]  cnt;
   logic [3:0]  next_cnt;
   logic [7:0]  sum;
   logic [7:0]  next_sum;
   logic [63:0] shreg;
   logic [63:0] next_shreg;
   logic        fv;
   logic        next_fv;
   ivc_frame_s  fr;
   ivc_frame_s  next_fr;
   logic        ok;
   logic        next_ok;

   always_comb
   begin
      next_cnt   = cnt;
      next_sum   = sum;
      next_shreg = shreg;
      next_fv    = 1'b0;
      next_fr    = fr;
      next_ok    = ok;
      if (byte_valid)
      begin
         if (cnt == IVC_POS_CSUM)
         begin
            next_cnt = IVC_CNT_RST;
            next_sum = IVC_BYTE_RST;
            next_fv  = 1'b1;
            next_fr  = {shreg, byte_data};
            next_ok  = (sum == byte_data);
         end
         else
         begin
            next_cnt   = cnt + 4'h1;
            next_sum   = sum + byte_data;
            next_shreg = {shreg[55:0], byte_data};
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt   <= IVC_CNT_RST;
         sum   <= IVC_BYTE_RST;
         shreg <= 64'h0000_0000_0000_0000;
         fv    <= 1'b0;
         fr    <= '0;
         ok    <= 1'b0;
      end
      else
      begin
         cnt   <= next_cnt;
         sum   <= next_sum;
         shreg <= next_shreg;
         fv    <= next_fv;
         fr    <= next_fr;
         ok    <= next_ok;
      end
   end

   assign frame_valid = fv;
   assign frame       = fr;
   assign csum_ok     = ok;

endmodule : ivc_frame_rx

/* ivc_props.sv */
// Purpose: Port checks for the indexed command block.
// Assumes: Whole frames only.
// Notes:   Bound below.
`timescale 1ns/1ps
module ivc_props
(
   input wire logic                 clk,
   input wire logic                 rst_n,
   input wire logic                 byte_valid,
   input wire logic                 reg_load,
   input wire logic [31:0]          accu,
   input wire logic [31:0]          xreg,
   input wire logic                 axis_wr_valid,
   input wire ivc_pkg::ivc_axis_wr_s axis_wr,
   input wire logic                 reply_valid,
   input wire ivc_pkg::ivc_reply_s   reply
);
   import ivc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_one; reply_valid |=> !reply_valid; endproperty
   a_one: assert property (p_one) else $error("long reply");
   property p_lat; reply_valid |-> $past(byte_valid, 2); endproperty
   a_lat: assert property (p_lat) else $error("reply latency");
   property p_ax; axis_wr_valid |-> reply_valid
      && reply.instr == IVC_OP_ACCU_TO_AXIS_PARAM_BY_INDEX
      && axis_wr.value == accu && axis_wr.axis == xreg[7:0]; endproperty
   a_ax: assert property (p_ax) else $error("axis write");
   property p_axo; reply_valid && reply.instr == IVC_OP_ACCU_TO_AXIS_PARAM_BY_INDEX
      && reply.status == IVC_ST_OK |-> axis_wr_valid; endproperty
   a_axo: assert property (p_axo) else $error("no axis write");
   property p_keep; reply_valid && reply.instr != IVC_OP_GET_INDEXED_USER_VAR
      && !$past(reg_load) |-> $stable(accu); endproperty
   a_keep: assert property (p_keep) else $error("accu moved");
   property p_rng; reply_valid && reply.instr == IVC_OP_GET_INDEXED_USER_VAR
      && xreg > IVC_IDX_MAX && !$past(reg_load) |-> $stable(accu); endproperty
   a_rng: assert property (p_rng) else $error("range ignored");
   property p_bad; reply_valid && reply.status == IVC_ST_BAD_CSUM && !$past(reg_load)
      |-> $stable(accu) && !axis_wr_valid; endproperty
   a_bad: assert property (p_bad) else $error("bad frame acted");
   property p_x; !$past(reg_load) |-> $stable(xreg); endproperty
   a_x: assert property (p_x) else $error("index moved");
endmodule : ivc_props
bind ivc_indexed_cmd ivc_props u_props (.clk(clk), .rst_n(rst_n), .byte_valid(byte_valid),
   .reg_load(reg_load), .accu(accu), .xreg(xreg), .axis_wr_valid(axis_wr_valid),
   .axis_wr(axis_wr), .reply_valid(reply_valid), .reply(reply));

/* ivc_host.sv */
// Purpose: Host that sends command frames.
// Assumes: One byte per clock.
// Notes:   Idle data shows the inverse of the last byte.
`timescale 1ns/1ps
module ivc_host
(
   input  wire logic  clk,
   output logic       byte_valid,
   output logic [7:0] byte_data
);
   import ivc_pkg::*;
   initial
   begin
      byte_valid = 1'b0;
      byte_data  = 8'h00;
   end
   task send(input ivc_frame_s f);
      for (int i = 0; i < IVC_FRAME_LEN; i++)
      begin
         @(posedge clk);
         #1;
         byte_valid = 1'b1;
         byte_data  = f[71-8*i -: 8];
      end
      @(posedge clk);
      #1;
      byte_valid = 1'b0;
      byte_data  = ~byte_data;
   endtask : send
endmodule : ivc_host

/* ivc_indexed_cmd_tb.sv */
// Purpose: Self-checking bench with a reference model.
// Assumes: Default parameters.
// Notes:   Random values from xorshift.
`timescale 1ns/1ps
module ivc_indexed_cmd_tb;
   import ivc_pkg::*;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         ld_en = 1'b0;
   logic [31:0]  a_in = '0;
   logic [31:0]  x_in = '0;
   logic         bv;
   logic [7:0]   bd;
   logic [31:0]  accu;
   logic [31:0]  xreg;
   logic         axv;
   logic         rv;
   ivc_axis_wr_s axw;
   ivc_reply_s   rep;
   int           n_fail = 0;
   int           check_count = 0;
   int           cyc = 0;
   logic [31:0]  seed = 32'd55810;
   logic [31:0]  m_acc = '0;
   logic [31:0]  m_x = '0;
   logic [31:0]  uv [256];
   logic [31:0]  xs [6] = '{32'h0, 32'hFF, 32'h100, 32'hFFFFFFFF, 32'h7, 32'h80};
   always #2.5 clk = ~clk;
   ivc_host host (.clk(clk), .byte_valid(bv), .byte_data(bd));
   ivc_indexed_cmd dut (.clk(clk), .rst_n(rst_n), .byte_valid(bv), .byte_data(bd),
      .reg_load(ld_en), .accu_in(a_in), .xreg_in(x_in), .accu(accu), .xreg(xreg),
      .axis_wr_valid(axv), .axis_wr(axw), .reply_valid(rv), .reply(rep));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task chk(input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
   endtask : chk
   task ld(input logic [31:0] a, input logic [31:0] x);
      @(posedge clk);
      #1;
      ld_en = 1'b1;
      a_in = a;
      x_in = x;
      @(posedge clk);
      #1;
      ld_en = 1'b0;
      m_acc = a;
      m_x = x;
   endtask : ld
   task cmd(input logic [7:0] op, input logic bad);
      ivc_frame_s f;
      logic [31:0] r;
      logic [7:0]  st;
      r = rnd();
      f = {r[7:0], op, (op == IVC_OP_SET_INDEXED_USER_VAR) ? 16'h0 : r[23:8],
         rnd(), 8'h00};
      f.csum = f.addr + f.instr + f.ptype + f.bank + f.value[31:24] + f.value[23:16]
         + f.value[15:8] + f.value[7:0] + bad;
      host.send(f);
      for (int n = 0; n < 4 && rv !== 1'b1; n++)
      begin
         @(posedge clk);
         #1;
      end
      st = bad ? IVC_ST_BAD_CSUM : (op inside {IVC_OP_ACCU_TO_AXIS_PARAM_BY_INDEX,
         IVC_OP_SET_INDEXED_USER_VAR, IVC_OP_GET_INDEXED_USER_VAR,
         IVC_OP_ACCU_TO_INDEXED_USER_VAR}) ? IVC_ST_OK : IVC_ST_BAD_CMD;
      if (st == IVC_ST_OK && m_x <= 32'hFF)
         case (op)
            IVC_OP_SET_INDEXED_USER_VAR: uv[m_x[7:0]] = f.value;
            IVC_OP_GET_INDEXED_USER_VAR: m_acc = uv[m_x[7:0]];
            IVC_OP_ACCU_TO_INDEXED_USER_VAR: uv[m_x[7:0]] = m_acc;
            default: ;
         endcase
      chk(32'h1, {31'h0, rv});
      chk({24'h0, st}, {24'h0, rep.status});
      chk({16'h0, f.addr, op}, {16'h0, rep.addr, rep.instr});
      chk(IVC_WORD_RST, rep.value);
      chk(m_acc, accu);
      chk(m_x, xreg);
      chk({31'h0, op == IVC_OP_ACCU_TO_AXIS_PARAM_BY_INDEX && !bad}, {31'h0, axv});
      if (axv === 1'b1)
      begin
         chk({m_x[7:0], f.ptype, 16'h0}, {axw.axis, axw.param, 16'h0});
         chk(m_acc, axw.value);
      end
   endtask : cmd
   task summarize;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         summarize();
      end
   end
   initial
   begin
      foreach (uv[i]) uv[i] = '0;
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      for (int k = 0; k < 10; k++)
      begin
         ld(rnd(), (k < 6) ? xs[k] : rnd() & 32'hFF);
         cmd(IVC_OP_SET_INDEXED_USER_VAR, 1'b0);
         cmd(IVC_OP_SET_INDEXED_USER_VAR, 1'b1);
         cmd(IVC_OP_GET_INDEXED_USER_VAR, 1'b0);
         cmd(IVC_OP_ACCU_TO_AXIS_PARAM_BY_INDEX, 1'b0);
         ld(rnd(), m_x);
         cmd(IVC_OP_ACCU_TO_INDEXED_USER_VAR, 1'b0);
         cmd(8'h40, 1'b0);
         ld(rnd(), m_x);
         cmd(IVC_OP_GET_INDEXED_USER_VAR, 1'b0);
      end
      // Read back the cells that a truncated out-of-range index would have hit.
      ld(rnd(), 32'h0000_0000);
      cmd(IVC_OP_GET_INDEXED_USER_VAR, 1'b0);
      ld(rnd(), 32'h0000_00FF);
      cmd(IVC_OP_GET_INDEXED_USER_VAR, 1'b0);
      summarize();
   end
endmodule : ivc_indexed_cmd_tb
